// >>> sync_sram_port.sv
/*
 * Pipelined synchronous static memory port: load/advance burst control,
 * three chip selects, per-lane writes, two-cycle data pipeline.
 * Assumes inputs are synchronous to clk and the master drives the bus
 * only in write data cycles; the board resolves the shared data wire.
 */
`timescale 1ns/10ps
module sync_sram_port
	import sram_port_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              clock_enable_n,
	input  wire logic              advance_or_load,
	input  wire logic              read_not_write,
	input  wire logic              chip_select_low_a,
	input  wire logic              chip_select_low_b,
	input  wire logic              chip_select_high,
	input  wire logic [LANES-1:0]  byte_write_enables_n,
	input  wire logic              burst_order_select,
	input  wire logic              output_enable_n,
	input  wire logic [AW-1:0]     address_inputs,
	input  wire logic [31:0]       data_io_in,
	input  wire logic [LANES-1:0]  parity_data_io_in,
	output logic      [31:0]       data_io_out,
	output logic      [LANES-1:0]  parity_data_io_out,
	output logic                   data_io_oe
);

	// ---------------------------------------------------------------
	// input decode
	// ---------------------------------------------------------------
	logic              ce;
	logic              selected;
	logic              load_cyc;
	logic              desel_cyc;
	logic              adv_step;
	burst_e            burst_state;
	logic [BURST_W-1:0] burst_cnt;
	logic [BURST_W-1:0] next_cnt;
	logic [AW-1:0]     burst_base;
	logic              burst_rd;
	logic [BURST_W-1:0] next_low;
	op_s               s1;
	op_s               s2;
	wr_s               wreg;
	logic              read_drive;
	logic [WORD_W-1:0] mem_q;
	logic [WORD_W-1:0] in_word;
	logic [WORD_W-1:0] rd_word;

	assign ce        = !clock_enable_n; // RULE7
	assign selected  = !chip_select_low_a && !chip_select_low_b && chip_select_high;
	assign load_cyc  = ce && !advance_or_load && selected; // RULE1
	assign desel_cyc = ce && !advance_or_load && !selected; // RULE13
	// a burst runs out after its fourth beat; further advances do nothing
	assign adv_step  = ce && advance_or_load && burst_state == BURST_RUN
		&& burst_cnt != BURST_LAST; // RULE4 RULE21
	assign next_cnt  = burst_cnt + BURST_STEP;
	assign next_low  = burst_order_select
		? (burst_base[BURST_W-1:0] ^ next_cnt) // RULE16 RULE22
		: (burst_base[BURST_W-1:0] + next_cnt); // RULE22

	// lane i is parity bit i on top of data byte i
	always_comb begin
		in_word = '0;
		for (int i = 0; i < LANES; i++) begin
			in_word[i*LANE_W +: LANE_W] = {parity_data_io_in[i], data_io_in[i*BYTE_W +: BYTE_W]};
		end
	end

	// ---------------------------------------------------------------
	// burst control
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			burst_state <= BURST_IDLE;
			burst_cnt   <= BURST_FIRST;
			burst_base  <= '0;
			burst_rd    <= 1'b0;
		end else if (load_cyc) begin
			// a load mid-burst simply restarts the counter
			burst_state <= BURST_RUN; // RULE2 RULE23
			burst_cnt   <= BURST_FIRST;
			burst_base  <= address_inputs; // RULE1
			burst_rd    <= read_not_write;
		end else if (desel_cyc) begin
			burst_state <= BURST_IDLE; // RULE3
			burst_cnt   <= BURST_FIRST;
		end else if (adv_step) begin
			burst_cnt <= next_cnt; // RULE4
		end else if (ce && advance_or_load && burst_cnt == BURST_LAST) begin
			burst_state <= BURST_IDLE; // RULE21
		end
	end

	// ---------------------------------------------------------------
	// address/control pipeline
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= '0;
		end else if (ce) begin
			if (load_cyc) begin
				s1.valid <= 1'b1; // RULE2
				s1.rd    <= read_not_write; // RULE6
				s1.addr  <= address_inputs;
				s1.be_n  <= byte_write_enables_n; // RULE9
			end else if (adv_step) begin
				// external address ignored; counter supplies the low bits
				s1.valid <= 1'b1; // RULE5
				s1.rd    <= burst_rd;
				s1.addr  <= {burst_base[AW-1:BURST_W], next_low};
				s1.be_n  <= byte_write_enables_n; // RULE10
			end else begin
				s1.valid <= 1'b0; // RULE3
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s2 <= '0;
		end else if (ce) begin
			s2 <= s1; // RULE6
		end
	end

	// ---------------------------------------------------------------
	// write data path
	// ---------------------------------------------------------------
	// data are registered on the transfer edge and committed one edge later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wreg <= '0;
		end else if (ce) begin
			wreg.valid <= s2.valid && !s2.rd; // RULE11
			wreg.addr  <= s2.addr;
			wreg.data  <= in_word; // RULE15
			wreg.lane_en <= ~s2.be_n; // RULE12
		end
	end

	sram_array #(
		.AW (AW),
		.NL (LANES),
		.LW (LANE_W)
	) u_array (
		.clk        (clk),
		.ce         (ce),
		.wr_en      (wreg.valid),
		.wr_addr    (wreg.addr),
		.wr_data    (wreg.data),
		.wr_lane_en (wreg.lane_en),
		.rd_addr    (s1.addr),
		.rd_data    (mem_q)
	);

	// ---------------------------------------------------------------
	// read data path
	// ---------------------------------------------------------------
	// a write captured one beat ahead has not reached the array yet
	always_comb begin
		rd_word = mem_q;
		for (int i = 0; i < LANES; i++) begin
			if (wreg.valid && wreg.lane_en[i] && wreg.addr == s2.addr) begin
				rd_word[i*LANE_W +: LANE_W] = wreg.data[i*LANE_W +: LANE_W];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_io_out        <= '0;
			parity_data_io_out <= '0;
		end else if (ce && s2.valid && s2.rd) begin
			for (int i = 0; i < LANES; i++) begin
				data_io_out[i*BYTE_W +: BYTE_W] <= rd_word[i*LANE_W +: BYTE_W]; // RULE15
				parity_data_io_out[i] <= rd_word[i*LANE_W + BYTE_W];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			read_drive <= 1'b0;
		end else if (ce) begin
			// writes and deselects release the bus on their transfer edge
			read_drive <= s2.valid && s2.rd; // RULE6 RULE14 RULE20
		end
	end

	// the only path not timed by clk: output enable gates drivers directly
	always_comb begin
		data_io_oe = read_drive && !output_enable_n; // RULE18 RULE19
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	load_capture_a: assert property ( // RULE1
		load_cyc |=> s1.valid && s1.addr == $past(address_inputs)
			&& s1.rd == $past(read_not_write))
		else $error("load did not capture address and control");

	deselect_end_a: assert property ( // RULE3
		desel_cyc |=> !s1.valid && burst_state == BURST_IDLE)
		else $error("deselect did not end burst");

	advance_addr_a: assert property ( // RULE5
		adv_step |=> s1.valid && s1.addr[AW-1:BURST_W] == $past(burst_base[AW-1:BURST_W]))
		else $error("advance used external address");

	burst_order_a: assert property ( // RULE16
		adv_step && burst_order_select |=>
			s1.addr[BURST_W-1:0] == ($past(burst_base[BURST_W-1:0]) ^ $past(next_cnt)))
		else $error("interleaved order wrong");

	suspend_hold_a: assert property ( // RULE7
		!ce |=> $stable(s1) && $stable(s2) && $stable(data_io_out) && $stable(read_drive))
		else $error("state changed while suspended");

	read_latency_a: assert property ( // RULE6
		load_cyc && read_not_write ##1 ce ##1 ce |-> ##1 read_drive)
		else $error("read data not driven two cycles after load");

	deselect_float_a: assert property ( // RULE14
		desel_cyc ##1 ce ##1 ce |-> ##1 !read_drive)
		else $error("bus not released two cycles after deselect");

	lane_write_a: assert property ( // RULE12
		ce && s2.valid && !s2.rd |=> wreg.valid && wreg.lane_en == ~$past(s2.be_n))
		else $error("write lanes do not follow enables");

	read_no_write_a: assert property ( // RULE11
		ce && s2.valid && s2.rd |=> !wreg.valid)
		else $error("read cycle produced a write");

	oe_float_a: assert property ( // RULE18
		output_enable_n |-> !data_io_oe)
		else $error("pins driven with output enable high");

	load_control_a: assert property ( // RULE2
		load_cyc |=> burst_state == BURST_RUN && burst_cnt == BURST_FIRST
			&& burst_base == $past(address_inputs) && burst_rd == $past(read_not_write))
		else $error("load did not store address and control");

	lane_capture_a: assert property ( // RULE9
		load_cyc |=> s1.be_n == $past(byte_write_enables_n))
		else $error("load did not capture lane enables");

	advance_count_a: assert property ( // RULE4
		adv_step |=> burst_cnt == $past(next_cnt) && s1.rd == $past(burst_rd))
		else $error("advance did not step burst counter");

	linear_order_a: assert property ( // RULE22
		adv_step && !burst_order_select |=> s1.addr[BURST_W-1:0]
			== BURST_W'($past(burst_base[BURST_W-1:0]) + $past(next_cnt)))
		else $error("linear order wrong");

	burst_limit_a: assert property ( // RULE21
		ce && advance_or_load && burst_cnt == BURST_LAST
			|=> !s1.valid && burst_state == BURST_IDLE)
		else $error("burst ran past four beats");

	idle_advance_a: assert property ( // RULE3
		ce && advance_or_load && burst_state == BURST_IDLE |=> !s1.valid)
		else $error("advance without burst started an access");

	select_decode_a: assert property ( // RULE13
		ce && !advance_or_load && (chip_select_low_a || chip_select_low_b
			|| !chip_select_high) |=> !s1.valid)
		else $error("access started while deselected");

	restart_burst_a: assert property ( // RULE23
		load_cyc && burst_state == BURST_RUN |=> s1.valid
			&& burst_cnt == BURST_FIRST && s1.addr == $past(address_inputs))
		else $error("load during burst did not restart");

	write_capture_a: assert property ( // RULE15
		ce && s2.valid && !s2.rd |=> wreg.data == $past(in_word)
			&& wreg.addr == $past(s2.addr))
		else $error("write data not registered on transfer edge");

	write_release_a: assert property ( // RULE6
		ce && s2.valid && !s2.rd |=> !read_drive)
		else $error("bus driven during write data cycle");

	read_out_a: assert property ( // RULE15
		ce && s2.valid && s2.rd |=> data_io_out[BYTE_W-1:0] == $past(rd_word[BYTE_W-1:0])
			&& parity_data_io_out[0] == $past(rd_word[BYTE_W]))
		else $error("read data not registered on transfer edge");

	// ---------------------------------------------------------------
	// cover points
	// ---------------------------------------------------------------
	read_load_c: cover property (load_cyc && read_not_write ##2 ce ##1 read_drive);
	write_load_c: cover property (load_cyc && !read_not_write ##1 ce ##1 ce ##1 wreg.valid);
	full_burst_c: cover property (load_cyc ##1 adv_step ##1 adv_step ##1 adv_step);
	suspend_c: cover property (s1.valid && !ce ##1 !ce ##1 ce);
	interleaved_c: cover property (burst_order_select && load_cyc ##1 adv_step ##1 adv_step);

endmodule // sync_sram_port

// >>> sram_port_pkg.sv
/*
 * Constants, types and field layouts shared by the pipelined synchronous
 * static memory port and its storage array.
 * Assumes a single rising-edge clock shared with the bus master.
 */
// Summary of operation
// (RULE1) address captured on load with chip selected
// (RULE2) load cycle stores new address and control
// (RULE3) load while deselected ends current burst
// (RULE4) advance cycle steps burst counter
// (RULE5) address inputs ignored on advance cycles
// (RULE6) data moves two cycles after load
// (RULE7) clock enable high freezes all state
// (RULE8) master holds clock enable low when active
// (RULE9) one active-low write enable per lane
// (RULE10) master drives byte enables every burst cycle
// (RULE11) byte enables ignored on read cycles
// (RULE12) only enabled lanes written, two cycles later
// (RULE13) load with any select false deselects
// (RULE14) bus floats two cycles after deselect
// (RULE15) write and read data paths registered
// (RULE16) order select high interleaved, low linear
// (RULE17) master keeps burst order select static
// (RULE18) output enable high floats pins asynchronously
// (RULE19) output enable may be tied low
// (RULE20) all else referenced to rising clock
// (RULE21) burst gives four beats from one address
// (RULE22) linear increments, interleaved xors low bits
// (RULE23) new load mid-burst starts new operation
package sram_port_pkg;

	localparam int ADDR_W    = 17;
	localparam int LANES     = 4;
	localparam int LANE_W    = 9;
	localparam int BYTE_W    = 8;
	localparam int WORD_W    = LANES * LANE_W;
	localparam int BURST_W   = 2;
	localparam int BURST_LEN = 4;

	localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_LAST  = 2'(BURST_LEN - 1);
	localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

	typedef enum logic [1:0] {
		BURST_IDLE = 2'b01,
		BURST_RUN  = 2'b10
	} burst_e;

	// one memory operation moving down the two-stage pipeline
	typedef struct packed {
		logic              valid;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  be_n;
	} op_s;

	// captured write waiting for its commit edge
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
		logic [LANES-1:0]  lane_en;
	} wr_s;

endpackage

// >>> sram_array.sv
/*
 * Storage array with one lane-masked write port and one registered read port.
 * Assumes the caller gates both ports with the shared clock enable.
 */
`timescale 1ns/10ps
module sram_array
	import sram_port_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int NL = LANES,
	parameter int LW = LANE_W
) (
	input  wire logic             clk,
	input  wire logic             ce,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [NL*LW-1:0] wr_data,
	input  wire logic [NL-1:0]    wr_lane_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [NL*LW-1:0] rd_data
);

	logic [NL*LW-1:0] mem [0:(1<<AW)-1];

	// write-first on a collision so a read two beats behind a write sees it
	always_ff @(posedge clk) begin
		if (ce) begin
			for (int i = 0; i < NL; i++) begin
				if (wr_en && wr_lane_en[i]) begin
					mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
				end
				if (wr_en && wr_lane_en[i] && wr_addr == rd_addr) begin
					rd_data[i*LW +: LW] <= wr_data[i*LW +: LW];
				end else begin
					rd_data[i*LW +: LW] <= mem[rd_addr][i*LW +: LW];
				end
			end
		end
	end

endmodule // sram_array

// >>> bus_wire_model.sv
/*
 * Far-side data wire model: resolves the shared data bus between the
 * bus master's write drive and the port's read drive.
 * Assumes the testbench supplies write data and its drive enable.
 */
`timescale 1ns/10ps
module bus_wire_model (
	input  wire logic        clk,
	input  wire logic        drive,
	input  wire logic [35:0] wd,
	input  wire logic [31:0] dev_data,
	input  wire logic [3:0]  dev_par,
	input  wire logic        dev_oe,
	output logic      [35:0] wire_val
);
	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	logic [35:0] last = 36'h0;

	// no pull on these lines: a released bus flips every cycle, never stale
	always_comb begin
		if (drive)
			wire_val = wd;
		else if (dev_oe)
			wire_val = {dev_par, dev_data};
		else
			wire_val = ~last;
	end

	always_ff @(posedge clk) begin
		last <= wire_val;
	end
endmodule // bus_wire_model

// >>> tb.sv
/*
 * Testbench for the pipelined synchronous memory port: load, advance,
 * deselect and suspend cycles with data and drive timing checked.
 * Assumes bus_wire_model resolves the shared data lines.
 */
`timescale 1ns/10ps
module tb;
	import sram_port_pkg::*;
	// ----------------------------------------
	// stimulus and reference model
	// ----------------------------------------
	typedef struct packed {
		logic              v;
		logic              rd;
		logic [ADDR_W-1:0] a;
		logic [LANES-1:0]  b;
		logic [7:0]        s;
	} exp_s;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              cen_n = 1'b1;
	logic              adv = 1'b0;
	logic              rnw = 1'b1;
	logic [2:0]        cs = 3'b000;
	logic [LANES-1:0]  be_n = 4'hf;
	logic              bos = 1'b0;
	logic              oe_n = 1'b0;
	logic              oe_hi = 1'b0;
	logic [ADDR_W-1:0] addr = 17'h0;
	logic              drive = 1'b0;
	logic [WORD_W-1:0] wd = 36'h0;
	logic [WORD_W-1:0] bus;
	logic [31:0]       q;
	logic [LANES-1:0]  qp;
	logic              oe;
	logic              prev_c = 1'b1;
	exp_s              nx = '0;
	exp_s              p [3] = '{default: '0};
	logic [2:0]        dsel [3] = '{3'b101, 3'b011, 3'b000};
	logic [WORD_W-1:0] mem [int];
	int                n_fail = 0;
	int                num_checks = 0;

	always #4 clk = ~clk;

	sync_sram_port sync_sram_port_inst (
		.clk(clk), .arst_n(arst_n), .clock_enable_n(cen_n), .advance_or_load(adv),
		.read_not_write(rnw), .chip_select_low_a(cs[2]), .chip_select_low_b(cs[1]),
		.chip_select_high(cs[0]), .byte_write_enables_n(be_n), .burst_order_select(bos),
		.output_enable_n(oe_n), .address_inputs(addr), .data_io_in(bus[31:0]),
		.parity_data_io_in(bus[35:32]), .data_io_out(q), .parity_data_io_out(qp),
		.data_io_oe(oe));
	bus_wire_model bus_wire_model_inst (.clk(clk), .drive(drive), .wd(wd),
		.dev_data(q), .dev_par(qp), .dev_oe(oe), .wire_val(bus));

	function automatic logic [35:0] pat(input logic [16:0] a, input logic [7:0] s);
		return {s[3:0], {4{s}} ^ {15'h0, a}};
	endfunction

	task automatic chk1(input logic g, input logic e, input string m);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic chkw(input logic [35:0] g, input logic [35:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic step(input logic c, input logic a, input logic r, input logic [2:0] s,
		input logic [3:0] b, input logic [16:0] ea, input logic v, input logic [7:0] t);
		logic [35:0] e;
		logic [35:0] w;
		@(posedge clk);
		if (!prev_c) begin
			p[2] = p[1];
			p[1] = p[0];
			p[0] = nx;
		end
		prev_c = c;
		nx = {v, r, ea, b, t};
		cen_n <= c;
		adv <= a;
		rnw <= r;
		cs <= s;
		be_n <= b;
		oe_n <= oe_hi;
		addr <= a ? ~ea : ea;
		drive <= p[1].v && !p[1].rd;
		wd <= pat(p[1].a, p[1].s);
		#1;
		if (p[2].v && !p[2].rd) begin
			e = mem.exists(p[2].a) ? mem[p[2].a] : 36'h0;
			w = pat(p[2].a, p[2].s);
			for (int i = 0; i < 4; i++)
				if (!p[2].b[i])
					e = (e & ~(36'hff << (i * 8) | 36'h1 << (32 + i)))
						| (w & (36'hff << (i * 8) | 36'h1 << (32 + i)));
			mem[p[2].a] = e;
		end
		chk1(oe, p[2].v && p[2].rd && !oe_n, "drive enable");
		if (p[2].v && p[2].rd)
			chkw({qp, q}, mem[p[2].a], "read data");
	endtask

	task automatic ld(input logic r, input logic [16:0] a, input logic [3:0] b,
		input logic [7:0] t);
		step(1'b0, 1'b0, r, 3'b001, b, a, 1'b1, t);
	endtask

	task automatic burst(input logic r, input logic [16:0] a0, input logic [7:0] t);
		for (int n = 0; n < 4; n++)
			step(1'b0, n != 0, r, 3'b001, 4'h0, {a0[16:2], bos ? a0[1:0] ^ 2'(n) :
				a0[1:0] + 2'(n)}, 1'b1, t);
	endtask

	task automatic idle(input int k);
		repeat (k) step(1'b0, 1'b0, 1'b1, 3'b000, 4'hf, 17'h0, 1'b0, 8'h0);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#20000;
		n_fail++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk1(oe, 1'b0, "reset drive");
		chkw({qp, q}, 36'h0, "reset data");
		burst(1'b0, 17'h6, 8'h11);
		burst(1'b1, 17'h6, 8'h00);
		ld(1'b0, 17'h5, 4'b0101, 8'h22);
		ld(1'b1, 17'h5, 4'hf, 8'h00);
		idle(3);
		$display("test bursts and lanes done");
		ld(1'b1, 17'h4, 4'h0, 8'h00);
		repeat (2) step(1'b1, 1'b0, 1'b0, 3'b001, 4'h0, 17'h7, 1'b0, 8'h33);
		ld(1'b1, 17'h6, 4'h0, 8'h00);
		step(1'b0, 1'b1, 1'b1, 3'b001, 4'h0, 17'h7, 1'b1, 8'h00);
		ld(1'b1, 17'h5, 4'h0, 8'h00);
		idle(3);
		$display("test suspend and restart done");
		foreach (dsel[i]) begin
			ld(1'b1, 17'h4, 4'h0, 8'h00);
			step(1'b0, 1'b0, 1'b1, dsel[i], 4'h0, 17'h6, 1'b0, 8'h00);
			step(1'b0, 1'b1, 1'b1, 3'b001, 4'h0, 17'h5, 1'b0, 8'h00);
			idle(2);
		end
		burst(1'b1, 17'h6, 8'h00);
		step(1'b0, 1'b1, 1'b1, 3'b001, 4'h0, 17'h6, 1'b0, 8'h00);
		oe_hi = 1'b1;
		burst(1'b1, 17'h4, 8'h00);
		oe_hi = 1'b0;
		idle(3);
		$display("test deselect and output enable done");
		@(posedge clk);
		arst_n <= 1'b0;
		bos <= 1'b1;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		p = '{default: '0};
		prev_c = 1'b1;
		burst(1'b1, 17'h5, 8'h00);
		idle(3);
		$display("test interleaved done");
		results();
	end
endmodule // tb
